// [itc_pkg.sv]
// ============================================================
// Interrupt controller shared constants
// ============================================================
package itc_pkg;

    // Register addresses on the special-function port
    localparam logic [7:0] ITC_ADDR_INT_ENABLE = 8'hA8;
    localparam logic [7:0] ITC_ADDR_SEC_ENABLE_LEVEL = 8'hA9;
    localparam logic [7:0] ITC_ADDR_INT_LEVEL = 8'hB8;

    // Reset values
    localparam logic [7:0] ITC_RST_INT_ENABLE = 8'h00;
    localparam logic [7:0] ITC_RST_SEC_ENABLE_LEVEL = 8'hA0;
    localparam logic [7:0] ITC_RST_INT_LEVEL = 8'h00;

    // Enable register fields
    localparam int ITC_GLOBAL_INT_ON = 7;
    localparam int ITC_CONV_IRQ_ON = 6;
    localparam int ITC_TIMER2_IRQ_ON = 5;
    localparam int ITC_UART_IRQ_ON = 4;
    localparam int ITC_TIMER1_IRQ_ON = 3;
    localparam int ITC_EXT1_IRQ_ON = 2;
    localparam int ITC_TIMER0_IRQ_ON = 1;
    localparam int ITC_EXT0_IRQ_ON = 0;

    // Level register fields
    localparam int ITC_LEVEL_UNUSED = 7;
    localparam int ITC_CONV_LEVEL = 6;
    localparam int ITC_TIMER2_LEVEL = 5;
    localparam int ITC_UART_LEVEL = 4;
    localparam int ITC_TIMER1_LEVEL = 3;
    localparam int ITC_EXT1_LEVEL = 2;
    localparam int ITC_TIMER0_LEVEL = 1;
    localparam int ITC_EXT0_LEVEL = 0;

    // Secondary enable and level register fields
    localparam int ITC_SEC_UNUSED = 7;
    localparam int ITC_INTERVAL_LEVEL = 6;
    localparam int ITC_SUPPLY_MON_LEVEL = 5;
    localparam int ITC_SYNC_SERIAL_LEVEL = 4;
    localparam int ITC_SEC_ZERO_BIT = 3;
    localparam int ITC_INTERVAL_IRQ_ON = 2;
    localparam int ITC_SUPPLY_MON_IRQ_ON = 1;
    localparam int ITC_SYNC_SERIAL_IRQ_ON = 0;

    // Number of sources and width of a source index
    localparam int ITC_NUM_SRC = 11;
    localparam int ITC_SRC_W = 4;

    // Source index in polling rank, index 0 polled first
    localparam logic [3:0] ITC_SRC_SUPPLY_MON = 4'h0;
    localparam logic [3:0] ITC_SRC_WATCHDOG = 4'h1;
    localparam logic [3:0] ITC_SRC_EXT0 = 4'h2;
    localparam logic [3:0] ITC_SRC_CONV = 4'h3;
    localparam logic [3:0] ITC_SRC_TIMER0 = 4'h4;
    localparam logic [3:0] ITC_SRC_EXT1 = 4'h5;
    localparam logic [3:0] ITC_SRC_TIMER1 = 4'h6;
    localparam logic [3:0] ITC_SRC_SYNC_SERIAL = 4'h7;
    localparam logic [3:0] ITC_SRC_UART = 4'h8;
    localparam logic [3:0] ITC_SRC_TIMER2 = 4'h9;
    localparam logic [3:0] ITC_SRC_INTERVAL = 4'hA;

    // Vector address of each source, in polling rank
    localparam logic [15:0] ITC_VECTOR [ITC_NUM_SRC] = '{
        16'h0043, 16'h005B, 16'h0003, 16'h0033, 16'h000B, 16'h0013,
        16'h001B, 16'h003B, 16'h0023, 16'h002B, 16'h0053
    };

endpackage

// [itc_top.sv]
`timescale 1ns/100ps
// What this block does
// - Enable bit 7 gates every source
// - Enable bits 6,5: converter, timer 2
// - Enable bits 4..0: uart, timers, externals
// - Level register bits 6..0: one means high
// - Secondary bits 6..4 set three source levels
// - Secondary bits 2..0 enable three sources
// - Bit 7 of level and secondary registers ignores writes
// - High level request preempts low handler
// - Simultaneous mixed levels: high served first
// - Same level never preempts running handler
// - Equal level ties follow fixed polling rank
// - Accepted request loads source fixed vector
module itc_top
    import itc_pkg::*;
(
    // Clock and asynchronous reset
    input wire logic clk,
    input wire logic arst_n,
    // Special-function register port
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    // Read data answers one cycle after the read strobe
    output logic [7:0] sfr_rdata,
    // Request levels from peripherals, in polling rank
    input wire logic supply_mon_irq,
    input wire logic watchdog_irq,
    input wire logic ext0_request,
    input wire logic conv_ready,
    input wire logic timer0_overflow,
    input wire logic ext1_request,
    input wire logic timer1_overflow,
    input wire logic sync_serial_irq,
    input wire logic uart_rxtx_flag,
    input wire logic timer2_flags,
    input wire logic interval_tick_irq,
    // Offer to the core
    output logic irq_req,
    output logic [15:0] irq_vector,
    output logic [3:0] irq_source,
    output logic irq_high,
    // Core answers: acceptance and handler return
    input wire logic irq_ack,
    input wire logic irq_return,
    // Handler levels now running
    output logic handler_high_active,
    output logic handler_low_active
);

    // ============================================================
    // State
    // ============================================================
    // One packed record holds every flop of the block
    typedef struct packed {
        logic [7:0] int_enable;     // Enable register
        logic [7:0] int_level;      // Level register
        logic [7:0] sec_enable;     // Secondary enable and level register
        // Nesting: low alone, high alone, or high over low
        logic act_hi;               // High level handler running
        logic act_lo;               // Low level handler running
        // Offer to the core, held in flops
        logic req;                  // Request offered to the core
        logic req_hi;               // Offered request is high level
        logic [3:0] src;            // Offered source index
        logic [15:0] vec;           // Offered vector address
        logic [7:0] rdata;          // Read data
    } itc_state_type;

    itc_state_type state_ff;        // Registered state
    itc_state_type nxt_state;       // Next state

    // Per-source vectors; bit index is the polling rank
    logic [ITC_NUM_SRC-1:0] pend;   // Raw requests in polling rank
    logic [ITC_NUM_SRC-1:0] src_on; // Per-source enable
    logic [ITC_NUM_SRC-1:0] src_hi; // Per-source level
    logic [ITC_NUM_SRC-1:0] elig;   // Enabled requests
    logic [ITC_NUM_SRC-1:0] cand_hi; // Eligible high level requests
    logic [ITC_NUM_SRC-1:0] cand_lo; // Eligible low level requests

    // ============================================================
    // Helpers
    // ============================================================
    // Index of the first set bit, lowest index wins
    // Shared by both levels so the tie order is written once
    function automatic logic [3:0] itc_first(input logic [ITC_NUM_SRC-1:0] v);
        logic [3:0] idx;
        // Empty vector gives zero; callers test for any bit
        idx = 4'h0;
        // Scan downwards so the lowest set index lands last
        for (int i = ITC_NUM_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction

    // ============================================================
    // Source mapping
    // ============================================================
    // Gather requests, enables and levels in polling rank
    // Pure wiring: no flops and no decoding of its own
    always_comb begin
        // Defaults keep every bit assigned
        pend = '0;
        src_on = '0;
        src_hi = '0;
        // Request levels, one per source
        pend[ITC_SRC_SUPPLY_MON] = supply_mon_irq;
        pend[ITC_SRC_WATCHDOG] = watchdog_irq;
        pend[ITC_SRC_EXT0] = ext0_request;
        pend[ITC_SRC_CONV] = conv_ready;
        pend[ITC_SRC_TIMER0] = timer0_overflow;
        pend[ITC_SRC_EXT1] = ext1_request;
        pend[ITC_SRC_TIMER1] = timer1_overflow;
        pend[ITC_SRC_SYNC_SERIAL] = sync_serial_irq;
        pend[ITC_SRC_UART] = uart_rxtx_flag;
        pend[ITC_SRC_TIMER2] = timer2_flags;
        pend[ITC_SRC_INTERVAL] = interval_tick_irq;
        // Enables from both enable registers
        src_on[ITC_SRC_CONV] = state_ff.int_enable[ITC_CONV_IRQ_ON];
        src_on[ITC_SRC_TIMER2] = state_ff.int_enable[ITC_TIMER2_IRQ_ON];
        src_on[ITC_SRC_UART] = state_ff.int_enable[ITC_UART_IRQ_ON];
        src_on[ITC_SRC_TIMER1] = state_ff.int_enable[ITC_TIMER1_IRQ_ON];
        src_on[ITC_SRC_EXT1] = state_ff.int_enable[ITC_EXT1_IRQ_ON];
        src_on[ITC_SRC_TIMER0] = state_ff.int_enable[ITC_TIMER0_IRQ_ON];
        src_on[ITC_SRC_EXT0] = state_ff.int_enable[ITC_EXT0_IRQ_ON];
        src_on[ITC_SRC_INTERVAL] = state_ff.sec_enable[ITC_INTERVAL_IRQ_ON];
        src_on[ITC_SRC_SUPPLY_MON] = state_ff.sec_enable[ITC_SUPPLY_MON_IRQ_ON];
        src_on[ITC_SRC_SYNC_SERIAL] = state_ff.sec_enable[ITC_SYNC_SERIAL_IRQ_ON];
        // Watchdog has no enable bit of its own here
        src_on[ITC_SRC_WATCHDOG] = 1'b1;
        // A one in a level bit makes the source high level
        // Levels from both level registers
        src_hi[ITC_SRC_CONV] = state_ff.int_level[ITC_CONV_LEVEL];
        src_hi[ITC_SRC_TIMER2] = state_ff.int_level[ITC_TIMER2_LEVEL];
        src_hi[ITC_SRC_UART] = state_ff.int_level[ITC_UART_LEVEL];
        src_hi[ITC_SRC_TIMER1] = state_ff.int_level[ITC_TIMER1_LEVEL];
        src_hi[ITC_SRC_EXT1] = state_ff.int_level[ITC_EXT1_LEVEL];
        src_hi[ITC_SRC_TIMER0] = state_ff.int_level[ITC_TIMER0_LEVEL];
        src_hi[ITC_SRC_EXT0] = state_ff.int_level[ITC_EXT0_LEVEL];
        src_hi[ITC_SRC_INTERVAL] = state_ff.sec_enable[ITC_INTERVAL_LEVEL];
        src_hi[ITC_SRC_SUPPLY_MON] = state_ff.sec_enable[ITC_SUPPLY_MON_LEVEL];
        src_hi[ITC_SRC_SYNC_SERIAL] = state_ff.sec_enable[ITC_SYNC_SERIAL_LEVEL];
        // Watchdog is treated as a high level source
        src_hi[ITC_SRC_WATCHDOG] = 1'b1;
    end

    // ============================================================
    // Arbitration
    // ============================================================
    // Arbitration reads registered enables and handler flags,
    // so a register write or a handler change reaches the
    // offer one cycle later; the core never sees a
    // half-updated winner
    // Gate by own and global enable; disabled requests just wait
    assign elig = pend & src_on
        & {ITC_NUM_SRC{state_ff.int_enable[ITC_GLOBAL_INT_ON]}};
    // High level may run unless a high handler is active
    assign cand_hi = elig & src_hi & {ITC_NUM_SRC{!state_ff.act_hi}};
    // Low level may run only when no handler is active
    assign cand_lo = elig & ~src_hi
        & {ITC_NUM_SRC{!state_ff.act_hi && !state_ff.act_lo}};

    // ============================================================
    // Next state
    // ============================================================
    // Next state from bus strobes, core answers and the winner
    always_comb begin
        // Default: every field holds its value
        nxt_state = state_ff;
        // Register writes
        if (sfr_wr) begin
            // Only the three addresses of this block decode
            case (sfr_addr)
                ITC_ADDR_INT_ENABLE: begin
                    // Global gate and seven enables, all writable
                    nxt_state.int_enable = sfr_wdata;
                end
                ITC_ADDR_INT_LEVEL: begin
                    // Bit 7 keeps its fixed value
                    nxt_state.int_level = sfr_wdata;
                    nxt_state.int_level[ITC_LEVEL_UNUSED] =
                        ITC_RST_INT_LEVEL[ITC_LEVEL_UNUSED];
                end
                ITC_ADDR_SEC_ENABLE_LEVEL: begin
                    // Bit 7 fixed; bit 3 is held at zero
                    nxt_state.sec_enable = sfr_wdata;
                    nxt_state.sec_enable[ITC_SEC_UNUSED] =
                        ITC_RST_SEC_ENABLE_LEVEL[ITC_SEC_UNUSED];
                    // A stray one in bit 3 is dropped, not stored
                    nxt_state.sec_enable[ITC_SEC_ZERO_BIT] = 1'b0;
                end
                default: begin
                    // Other addresses belong elsewhere
                end
            endcase
        end
        // Registered read data; unmapped addresses read zero
        if (sfr_rd) begin
            // A read sees the value before a same-cycle write
            case (sfr_addr)
                ITC_ADDR_INT_ENABLE: begin
                    // Enable register as stored
                    nxt_state.rdata = state_ff.int_enable;
                end
                ITC_ADDR_INT_LEVEL: begin
                    // Level register, bit 7 reads its fixed zero
                    nxt_state.rdata = state_ff.int_level;
                end
                ITC_ADDR_SEC_ENABLE_LEVEL: begin
                    // Secondary register, bit 7 reads its fixed one
                    nxt_state.rdata = state_ff.sec_enable;
                end
                default: begin
                    // Foreign address: answer zero
                    nxt_state.rdata = 8'h00;
                end
            endcase
        end
        // Handler return releases the innermost level
        // Return is taken before acceptance, so both in one
        // cycle end the old handler and start the new one
        if (irq_return) begin
            if (state_ff.act_hi) begin
                // High handler is the innermost one
                nxt_state.act_hi = 1'b0;
            end else begin
                // Only a low handler can be running
                nxt_state.act_lo = 1'b0;
            end
        end
        // Acceptance marks the offered level as running
        if (irq_ack && state_ff.req) begin
            if (state_ff.req_hi) begin
                // High handler, possibly nested over a low one
                nxt_state.act_hi = 1'b1;
            end else begin
                // Low handler
                nxt_state.act_lo = 1'b1;
            end
        end
        // Offer the winner; an ack cycle drops the offer once
        // That gap keeps the core from taking one request twice
        // Default: nothing offered this cycle
        nxt_state.req = 1'b0;
        nxt_state.req_hi = 1'b0;
        if (!(irq_ack && state_ff.req)) begin
            if (|cand_hi) begin
                // High level beats any low level request
                nxt_state.req = 1'b1;
                nxt_state.req_hi = 1'b1;
                // Source and vector always move together
                nxt_state.src = itc_first(cand_hi);
                nxt_state.vec = ITC_VECTOR[itc_first(cand_hi)];
            end else if (|cand_lo) begin
                // No high request: first low request in rank
                nxt_state.req = 1'b1;
                nxt_state.src = itc_first(cand_lo);
                nxt_state.vec = ITC_VECTOR[itc_first(cand_lo)];
            end
        end
    end

    // ============================================================
    // Registers
    // ============================================================
    // Asynchronous reset loads constants only
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            // Clear all, then load the register defaults
            state_ff <= '0;
            state_ff.int_enable <= ITC_RST_INT_ENABLE;
            state_ff.int_level <= ITC_RST_INT_LEVEL;
            state_ff.sec_enable <= ITC_RST_SEC_ENABLE_LEVEL;
        end else begin
            // Take the next state on every edge
            state_ff <= nxt_state;
        end
    end

    // ============================================================
    // Outputs
    // ============================================================
    // Outputs come straight from flops, so the core and the bus
    // see clean values with no path through the arbiter
    // Vector and source hold their value after an offer drops
    assign sfr_rdata = state_ff.rdata;
    assign irq_req = state_ff.req;
    assign irq_vector = state_ff.vec;
    assign irq_source = state_ff.src;
    assign irq_high = state_ff.req_hi;
    assign handler_high_active = state_ff.act_hi;
    assign handler_low_active = state_ff.act_lo;

endmodule

// [itc_top_asserts.sv]
`timescale 1ns/100ps
// ====================================================
// Port checker for the interrupt controller
module itc_top_asserts
    import itc_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_rdata,
    input wire logic irq_req,
    input wire logic [15:0] irq_vector,
    input wire logic [3:0] irq_source,
    input wire logic irq_high,
    input wire logic irq_ack,
    input wire logic irq_return,
    input wire logic handler_high_active,
    input wire logic handler_low_active
);
    // Shadow copies of the three registers as software wrote them
    logic [7:0] ie_sh, ip_sh, sec_sh;
    // Enable and level views one edge old, as the arbiter saw them
    logic [10:0] en_q, lv_q;
    logic ge_q;
    logic [7:0] rd_exp;

    // Per source bit in polling rank; watchdog is always on and high
    function automatic logic [10:0] src_bits(logic [7:0] e, logic [7:0] s);
        return {s[2], e[5], e[4], s[0], e[3], e[2], e[1], e[6], e[0], 1'b1, s[1]};
    endfunction

    // Expected read data for the address on the bus
    assign rd_exp = (sfr_addr == ITC_ADDR_INT_ENABLE) ? ie_sh :
        (sfr_addr == ITC_ADDR_INT_LEVEL) ? ip_sh :
        (sfr_addr == ITC_ADDR_SEC_ENABLE_LEVEL) ? sec_sh : 8'h00;

    // Shadow registers follow writes, unused bits held fixed
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ie_sh <= ITC_RST_INT_ENABLE;
            ip_sh <= ITC_RST_INT_LEVEL;
            sec_sh <= ITC_RST_SEC_ENABLE_LEVEL;
            en_q <= '0;
            lv_q <= '0;
            ge_q <= 1'b0;
        end else begin
            if (sfr_wr && sfr_addr == ITC_ADDR_INT_ENABLE) begin
                ie_sh <= sfr_wdata;
            end
            if (sfr_wr && sfr_addr == ITC_ADDR_INT_LEVEL) begin
                ip_sh <= sfr_wdata & 8'h7F;
            end
            if (sfr_wr && sfr_addr == ITC_ADDR_SEC_ENABLE_LEVEL) begin
                sec_sh <= (sfr_wdata | 8'h80) & 8'hF7;
            end
            en_q <= src_bits(ie_sh, sec_sh);
            lv_q <= src_bits(ip_sh, sec_sh >> 4);
            ge_q <= ie_sh[7];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    glob_gate_a: assert property (irq_req |-> ge_q)
        else $error("offer while global enable clear");
    own_enable_a: assert property (irq_req |-> en_q[irq_source])
        else $error("offer from disabled source");
    level_map_a: assert property (irq_req |-> irq_high == lv_q[irq_source])
        else $error("offer level differs from level bits");
    vector_map_a: assert property (irq_req |-> irq_vector == ITC_VECTOR[irq_source])
        else $error("vector does not match source");
    reg_readback_a: assert property (sfr_rd |=> sfr_rdata == $past(rd_exp))
        else $error("register read value wrong");
    ack_gap_a: assert property (irq_ack && irq_req |=> !irq_req)
        else $error("offer not withdrawn after acceptance");
    handler_set_a: assert property (irq_ack && irq_req && !irq_return |=>
        ($past(irq_high) ? handler_high_active : handler_low_active))
        else $error("accepted handler level not marked active");
    low_block_a: assert property (handler_low_active && irq_req |-> irq_high)
        else $error("low offer during running handler");
    high_block_a: assert property (handler_high_active |-> !irq_req)
        else $error("offer during high handler");
    preempt_nest_a: assert property (handler_low_active && !handler_high_active &&
        irq_req && irq_ack && !irq_return |=> handler_high_active && handler_low_active)
        else $error("high request did not nest over low handler");

    cover property (irq_ack && irq_req);
    cover property (handler_low_active && handler_high_active);
    cover property (sfr_rd && sfr_addr == ITC_ADDR_SEC_ENABLE_LEVEL);
endmodule

bind itc_top itc_top_asserts u_chk (.clk(clk), .arst_n(arst_n), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq_source(irq_source),
    .irq_high(irq_high), .irq_ack(irq_ack), .irq_return(irq_return),
    .handler_high_active(handler_high_active), .handler_low_active(handler_low_active));

// [itc_core_model.sv]
`timescale 1ns/100ps
// ====================================================
// Core side: takes offers after a set lag, ends handlers on command
module itc_core_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic irq_req,
    input wire logic ack_on,
    input wire logic ret_go,
    input wire logic [2:0] lag,
    output logic irq_ack = 1'b0,
    output logic irq_return = 1'b0
);
    logic on_s, go_s;
    int seen;
    // Commands sampled at the edge, answers driven just after it
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_ack = 1'b0;
            irq_return = 1'b0;
            seen = 0;
        end else begin
            on_s = ack_on;
            go_s = ret_go;
            #1;
            irq_ack = 1'b0;
            irq_return = go_s;
            if (on_s && irq_req && seen >= lag) begin
                irq_ack = 1'b1;
                seen = 0;
            end else if (on_s && irq_req) begin
                seen++;
            end else begin
                seen = 0;
            end
        end
    end
endmodule

// [itc_top_test.sv]
`timescale 1ns/100ps
// ====================================================
// Self-checking bench for the interrupt controller
module itc_top_test;
    logic clk, arst_n, sfr_wr, sfr_rd, irq_ack, irq_return, ack_on, ret_go;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic [10:0] req;
    logic irq_req, irq_high, handler_high_active, handler_low_active;
    logic [15:0] irq_vector;
    logic [3:0] irq_source;
    logic [2:0] lag;
    int bad_count, cmp_count;
    // Vector, enable bit and register of each source in polling rank
    logic [15:0] vec [11] = '{16'h0043, 16'h005B, 16'h0003, 16'h0033, 16'h000B, 16'h0013,
        16'h001B, 16'h003B, 16'h0023, 16'h002B, 16'h0053};
    int ebit [11] = '{1, 0, 0, 6, 1, 2, 3, 0, 4, 5, 2};
    logic [10:0] in_sec = 11'h481;

    itc_top DUT (.clk(clk), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .supply_mon_irq(req[0]),
        .watchdog_irq(req[1]), .ext0_request(req[2]), .conv_ready(req[3]),
        .timer0_overflow(req[4]), .ext1_request(req[5]), .timer1_overflow(req[6]),
        .sync_serial_irq(req[7]), .uart_rxtx_flag(req[8]), .timer2_flags(req[9]),
        .interval_tick_irq(req[10]), .irq_req(irq_req), .irq_vector(irq_vector),
        .irq_source(irq_source), .irq_high(irq_high), .irq_ack(irq_ack),
        .irq_return(irq_return), .handler_high_active(handler_high_active),
        .handler_low_active(handler_low_active));
    itc_core_model u_core (.clk(clk), .arst_n(arst_n), .irq_req(irq_req), .ack_on(ack_on),
        .ret_go(ret_go), .lag(lag), .irq_ack(irq_ack), .irq_return(irq_return));

    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ====================================================
    // Shared tasks
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        tick(1);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        tick(1);
        sfr_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        tick(1);
        sfr_addr = a;
        sfr_rd = 1'b1;
        tick(1);
        sfr_rd = 1'b0;
        tick(1);
        chk(16'(sfr_rdata), 16'(exp));
    endtask
    // Writes enable, level and secondary registers, then lets the offer settle
    task automatic cfg(input logic [7:0] e, input logic [7:0] p, input logic [7:0] s);
        wr(8'hA8, e);
        wr(8'hB8, p);
        wr(8'hA9, s);
        tick(2);
    endtask
    task automatic offer(input int i, input logic h);
        chk(16'(irq_req), 16'h0001);
        chk(16'(irq_source), 16'(i));
        chk(irq_vector, vec[i]);
        chk(16'(irq_high), 16'(h));
    endtask
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ====================================================
    // Scenarios
    task automatic t_regs;
        rd(8'hA8, 8'h00);
        rd(8'hA9, 8'hA0);
        rd(8'hB8, 8'h00);
        wr(8'hB8, 8'hFF);
        rd(8'hB8, 8'h7F);
        wr(8'hA9, 8'h77);
        rd(8'hA9, 8'hF7);
        wr(8'hC0, 8'h55);
        rd(8'hC0, 8'h00);
        $display("register test done");
    endtask
    task automatic t_gate;
        req = 11'h7FF;
        cfg(8'h7F, 8'h00, 8'h07);
        chk(16'(irq_req), 16'h0000);
        req = 11'h002;
        cfg(8'h80, 8'h00, 8'h00);
        offer(1, 1'b1);
        req = 11'h7FD;
        tick(2);
        chk(16'(irq_req), 16'h0000);
        $display("gate test done");
    endtask
    task automatic t_bits;
        logic [7:0] m;
        for (int i = 0; i < 11; i++) begin
            if (i == 1) continue;
            m = 8'(1 << ebit[i]);
            cfg(in_sec[i] ? 8'h80 : 8'h80 | m, 8'h00, in_sec[i] ? m : 8'h00);
            offer(i, 1'b0);
            cfg(8'hFF, in_sec[i] ? 8'h00 : m, in_sec[i] ? (m << 4) | 8'h07 : 8'h07);
            offer(i, 1'b1);
        end
        $display("bit map test done");
    endtask
    task automatic t_rank;
        req = 11'h006;
        cfg(8'h81, 8'h01, 8'h00);
        offer(1, 1'b1);
        req = 11'h7FD;
        cfg(8'hFF, 8'h00, 8'h07);
        for (int i = 0; i < 11; i++) begin
            if (i == 1) continue;
            offer(i, 1'b0);
            req[i] = 1'b0;
            tick(2);
        end
        $display("rank test done");
    endtask
    task automatic t_nest;
        req = 11'h000;
        cfg(8'hFF, 8'h40, 8'h07);
        ack_on = 1'b1;
        req[4] = 1'b1;
        tick(4);
        chk(16'(handler_low_active), 16'h0001);
        req[4] = 1'b0;
        ack_on = 1'b0;
        req[6] = 1'b1;
        tick(4);
        chk(16'(irq_req), 16'h0000);
        lag = 3'h3;
        ack_on = 1'b1;
        req[3] = 1'b1;
        tick(8);
        chk(16'(handler_high_active), 16'h0001);
        req[3] = 1'b0;
        ack_on = 1'b0;
        ret_go = 1'b1;
        tick(1);
        ret_go = 1'b0;
        tick(2);
        chk(16'({handler_high_active, handler_low_active, irq_req}), 16'h0002);
        ret_go = 1'b1;
        tick(1);
        ret_go = 1'b0;
        tick(3);
        offer(6, 1'b0);
        $display("nesting test done");
    endtask

    // Main sequence
    initial begin
        arst_n = 1'b0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        req = 11'h000;
        ack_on = 1'b0;
        ret_go = 1'b0;
        lag = 3'h0;
        bad_count = 0;
        cmp_count = 0;
        tick(10);
        arst_n = 1'b1;
        t_regs;
        t_gate;
        t_bits;
        t_rank;
        t_nest;
        tally_and_finish;
    end
    // Cuts a hang short
    initial begin
        #1000000;
        bad_count++;
        tally_and_finish;
    end
endmodule
